// File: src/ocdf_defs.svh
// register map, field positions, reset values and codes for the output clock control
`ifndef OCDF_DEFS_SVH
`define OCDF_DEFS_SVH

`define OCDF_ADDR_W 12
`define OCDF_ENABLE_OFFS 12'h000
`define OCDF_MUX_OFFS 12'h004
`define OCDF_STATUS_OFFS 12'h008
`define OCDF_OUT_BASE 12'h100
`define OCDF_OUT_SHIFT 5
`define OCDF_CR1_SUB 5'h00
`define OCDF_CR2_SUB 5'h04
`define OCDF_CR3_SUB 5'h08
`define OCDF_DIV_SUB 5'h0C
`define OCDF_DIFF_SUB 5'h10

`define OCDF_CR2_INV_BIT 4
`define OCDF_CR2_DRIVE_LSB 5
`define OCDF_CR3_NEGLS_BIT 1
`define OCDF_DIFF_CM_LSB 4
`define OCDF_STATUS_ACT_LSB 16
`define OCDF_MUX_FIELD_W 2

`define OCDF_MSD_RST 7'h00
`define OCDF_LOWDIV_RST 24'h000000
`define OCDF_DRIVE_RST 2'h3
`define OCDF_SWING_RST 4'h8
`define OCDF_CM_RST 4'h0
`define OCDF_FIXED_SWING 4'h4

`endif

// File: src/ocdf_pkg.sv
// types shared by the output clock control block
package ocdf_pkg;

  typedef enum logic [3:0] {
    FMT_DISABLED = 4'h0,
    FMT_DIFF_FIXED = 4'h1,
    FMT_DIFF_PROG = 4'h2,
    FMT_HCSL = 4'h3,
    FMT_CMOS_NOFF = 4'h4,
    FMT_CMOS_NSAME = 4'h5,
    FMT_CMOS_NINV = 4'h6,
    FMT_HSTL = 4'h7
  } ocdf_fmt_t;

  typedef struct packed {
    logic [3:0] fmt;
    logic inv;
    logic [1:0] drive;
    logic [6:0] msd;
    logic low_speed_path_select;
    logic negLs;
    logic [23:0] low_speed_divide;
    logic [3:0] swing;
    logic [3:0] cm;
  } ocdf_cfg_t;

  typedef struct packed {
    logic pos;
    logic posOe;
    logic neg;
    logic negOe;
  } ocdf_pin_t;

  typedef struct packed {
    logic lowPower;
    logic [1:0] drive;
    logic [3:0] swing;
    logic [3:0] cm;
  } ocdf_drv_t;

endpackage

// File: src/ocdf_half_divider.sv
// divider with 50% duty for any ratio, counting both edges of its input clock
`timescale 1ns/1ns
module ocdf_half_divider #(
  parameter int WIDTH = 7
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic tick,
  input wire logic [WIDTH-1:0] ratioM1,
  output logic clkOut,
  output logic edgeOut
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic clk;
  } ocdf_divst_t;

  ocdf_divst_t s_q;
  ocdf_divst_t s_d;

  ////////////////////////////////////////////////////////////////////////
  // toggle after ratio input edges: period is ratio input periods
  always_comb begin
    s_d = s_q;
    edgeOut = 1'b0;
    if (!enable) begin
      s_d = '0;
    end else if (tick) begin
      if (s_q.cnt >= ratioM1) begin
        s_d.cnt = '0;
        s_d.clk = ~s_q.clk;
        edgeOut = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + WIDTH'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clkOut = s_q.clk;

  ////////////////////////////////////////////////////////////////////////
  property p_toggleOnCount;
    @(posedge sys_clk) disable iff (!rst_n)
      enable && tick && s_q.cnt == ratioM1 |=> clkOut != $past(clkOut);
  endproperty
  a_toggleOnCount: assert property (p_toggleOnCount) else $error("divider missed toggle");

  property p_holdBetween;
    @(posedge sys_clk) disable iff (!rst_n)
      enable && (!tick || s_q.cnt < ratioM1) |=> $stable(clkOut);
  endproperty
  a_holdBetween: assert property (p_holdBetween) else $error("divider toggled early");

  property p_stopWhenOff;
    @(posedge sys_clk) disable iff (!rst_n)
      !enable |=> !clkOut && s_q.cnt == '0;
  endproperty
  a_stopWhenOff: assert property (p_stopWhenOff) else $error("divider runs while off");

  c_oddRatio: cover property (@(posedge sys_clk) disable iff (!rst_n)
    enable && ratioM1[0] == 1'b0 && ratioM1 != '0 && edgeOut);

endmodule

// File: src/ocdf_output_ctrl.sv
// per-output clock dividers, source mux and format control behind an APB slave
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "ocdf_defs.svh"
module ocdf_output_ctrl #(
  parameter int NumOutputs = 6,
  parameter int NumBanks = 6
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] srcClk,
  output ocdf_pkg::ocdf_pin_t [NumOutputs-1:0] pins,
  output ocdf_pkg::ocdf_drv_t [NumOutputs-1:0] drv
);

  typedef struct packed {
    ocdf_pkg::ocdf_cfg_t [NumOutputs-1:0] cfg;
    logic [NumOutputs-1:0] en;
    logic [NumBanks-1:0][1:0] mux;
    logic [NumOutputs-1:0] srcPrev;
    ocdf_pkg::ocdf_pin_t [NumOutputs-1:0] pin;
    ocdf_pkg::ocdf_drv_t [NumOutputs-1:0] drv;
    logic [31:0] rdata;
    logic err;
  } ocdf_state_t;

  ocdf_state_t s_q;
  ocdf_state_t s_d;

  // ten-output parts share banks 2-1-2-2-1-2, six-output parts one per bank
  function automatic int bankOf(input int idx);
    int b;
    b = idx;
    if (NumOutputs == 10) begin
      case (idx)
        0, 1: b = 0;
        2: b = 1;
        3, 4: b = 2;
        5, 6: b = 3;
        7: b = 4;
        default: b = 5;
      endcase
    end
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // clock path per output
  logic [NumOutputs-1:0] srcLvl;
  logic [NumOutputs-1:0] tick;
  logic [NumOutputs-1:0] active;
  logic [NumOutputs-1:0] divOn;
  logic [NumOutputs-1:0] dual;
  logic [NumOutputs-1:0] pDrv;
  logic [NumOutputs-1:0] nDrv;

  for (genvar i = 0; i < NumOutputs; i++) begin : gOut
    logic midClk;
    logic midEdge;
    logic lowClk;
    logic midSel;
    logic pClk;
    logic nClk;
    ocdf_pkg::ocdf_cfg_t c;

    assign c = s_q.cfg[i];
    assign srcLvl[i] = srcClk[s_q.mux[bankOf(i)]];
    assign tick[i] = srcLvl[i] != s_q.srcPrev[i];
    assign active[i] = (c.fmt != 4'h0) && s_q.en[i];
    assign divOn[i] = s_q.en[i] && (c.msd != 7'h00);

    ocdf_half_divider #(.WIDTH(7)) uMid (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .enable(divOn[i]),
      .tick(tick[i]),
      .ratioM1(c.msd),
      .clkOut(midClk),
      .edgeOut(midEdge)
    );

    ocdf_half_divider #(.WIDTH(24)) uLow (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .enable(divOn[i]),
      .tick(midEdge),
      .ratioM1(c.low_speed_divide),
      .clkOut(lowClk),
      .edgeOut()
    );

    assign midSel = (c.msd == 7'h00) ? srcLvl[i] : midClk;
    // dual mode is gated off in logic while the mid field is zero
    assign dual[i] = !c.low_speed_path_select && c.negLs && (c.msd != 7'h00);
    assign pClk = (c.low_speed_path_select && c.msd != 7'h00) ? lowClk : midSel;
    assign nClk = dual[i] ? lowClk : pClk;
    assign pDrv[i] = pClk ^ c.inv;
    assign nDrv[i] = nClk ^ c.inv;
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  logic [11:0] outOffs;
  logic [6:0] outIdx;
  logic [4:0] sub;
  logic outHit;
  logic regHit;
  logic [31:0] rdVal;
  ocdf_pkg::ocdf_cfg_t selCfg;

  always_comb begin
    outOffs = paddr - `OCDF_OUT_BASE;
    outIdx = 7'(outOffs >> `OCDF_OUT_SHIFT);
    sub = outOffs[4:0];
    outHit = (paddr >= `OCDF_OUT_BASE) && (int'(outIdx) < NumOutputs)
      && (sub <= `OCDF_DIFF_SUB) && (paddr[1:0] == 2'h0);
    selCfg = '0;
    if (outHit) begin
      selCfg = s_q.cfg[outIdx];
    end
    regHit = outHit;
    rdVal = 32'h00000000;
    case (paddr)
      `OCDF_ENABLE_OFFS: begin
        regHit = 1'b1;
        rdVal = 32'(s_q.en);
      end
      `OCDF_MUX_OFFS: begin
        regHit = 1'b1;
        rdVal = 32'(s_q.mux);
      end
      `OCDF_STATUS_OFFS: begin
        regHit = 1'b1;
        for (int i = 0; i < NumOutputs; i++) begin
          rdVal[i] = s_q.pin[i].pos;
          rdVal[`OCDF_STATUS_ACT_LSB + i] = active[i];
        end
      end
      default: begin
        if (outHit) begin
          case (sub)
            `OCDF_CR1_SUB: rdVal = 32'(selCfg.msd);
            `OCDF_CR2_SUB: rdVal = 32'({selCfg.drive, selCfg.inv, selCfg.fmt});
            `OCDF_CR3_SUB: rdVal = 32'({selCfg.negLs, selCfg.low_speed_path_select});
            `OCDF_DIV_SUB: rdVal = 32'(selCfg.low_speed_divide);
            `OCDF_DIFF_SUB: rdVal = 32'({selCfg.cm, selCfg.swing});
            default: regHit = 1'b0;
          endcase
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    s_d.srcPrev = srcLvl;
    if (psel && !penable) begin
      s_d.rdata = rdVal;
      s_d.err = !regHit || (pwrite && paddr == `OCDF_STATUS_OFFS);
    end
    if (psel && penable && pwrite && !s_q.err) begin
      if (paddr == `OCDF_ENABLE_OFFS) begin
        s_d.en = pwdata[NumOutputs-1:0];
      end else if (paddr == `OCDF_MUX_OFFS) begin
        s_d.mux = pwdata[2*NumBanks-1:0];
      end else if (outHit) begin
        case (sub)
          `OCDF_CR1_SUB: s_d.cfg[outIdx].msd = pwdata[6:0];
          `OCDF_CR2_SUB: begin
            s_d.cfg[outIdx].fmt = pwdata[3:0];
            s_d.cfg[outIdx].inv = pwdata[`OCDF_CR2_INV_BIT];
            s_d.cfg[outIdx].drive = pwdata[`OCDF_CR2_DRIVE_LSB +: 2];
          end
          `OCDF_CR3_SUB: begin
            s_d.cfg[outIdx].low_speed_path_select = pwdata[0];
            s_d.cfg[outIdx].negLs = pwdata[`OCDF_CR3_NEGLS_BIT];
          end
          `OCDF_DIV_SUB: s_d.cfg[outIdx].low_speed_divide = pwdata[23:0];
          default: begin
            s_d.cfg[outIdx].swing = pwdata[3:0];
            s_d.cfg[outIdx].cm = pwdata[`OCDF_DIFF_CM_LSB +: 4];
          end
        endcase
      end
    end
    for (int i = 0; i < NumOutputs; i++) begin
      s_d.pin[i] = '0;
      s_d.drv[i].lowPower = (s_q.cfg[i].fmt == 4'h0);
      s_d.drv[i].drive = s_q.cfg[i].drive;
      s_d.drv[i].cm = s_q.cfg[i].cm;
      s_d.drv[i].swing = s_q.cfg[i].swing;
      if (s_q.cfg[i].fmt == ocdf_pkg::FMT_DIFF_FIXED) begin
        s_d.drv[i].swing = `OCDF_FIXED_SWING;
      end
      if (active[i]) begin
        s_d.pin[i].pos = pDrv[i];
        s_d.pin[i].posOe = 1'b1;
        s_d.pin[i].neg = ~pDrv[i];
        s_d.pin[i].negOe = 1'b1;
        case (s_q.cfg[i].fmt)
          ocdf_pkg::FMT_DIFF_FIXED, ocdf_pkg::FMT_DIFF_PROG,
          ocdf_pkg::FMT_HCSL, ocdf_pkg::FMT_HSTL: begin
          end
          ocdf_pkg::FMT_CMOS_NOFF: begin
            s_d.pin[i].neg = 1'b0;
            s_d.pin[i].negOe = 1'b0;
          end
          ocdf_pkg::FMT_CMOS_NSAME: begin
            s_d.pin[i].neg = dual[i] ? nDrv[i] : pDrv[i];
          end
          ocdf_pkg::FMT_CMOS_NINV: begin
            s_d.pin[i].neg = dual[i] ? nDrv[i] : ~pDrv[i];
          end
          default: begin
            s_d.pin[i] = '0;
            s_d.drv[i].lowPower = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q <= '0;
      for (int i = 0; i < NumOutputs; i++) begin
        s_q.cfg[i].msd <= `OCDF_MSD_RST;
        s_q.cfg[i].low_speed_divide <= `OCDF_LOWDIV_RST;
        s_q.cfg[i].drive <= `OCDF_DRIVE_RST;
        s_q.cfg[i].swing <= `OCDF_SWING_RST;
        s_q.cfg[i].cm <= `OCDF_CM_RST;
        s_q.drv[i].lowPower <= 1'b1;
        s_q.drv[i].drive <= `OCDF_DRIVE_RST;
        s_q.drv[i].swing <= `OCDF_SWING_RST;
        s_q.drv[i].cm <= `OCDF_CM_RST;
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && s_q.err;
  assign pins = s_q.pin;
  assign drv = s_q.drv;

  ////////////////////////////////////////////////////////////////////////
  // checks on output 0
  property p_disabledHiZ;
    @(posedge sys_clk) disable iff (!rst_n)
      s_q.cfg[0].fmt == 4'h0 |=> !pins[0].posOe && !pins[0].negOe && drv[0].lowPower;
  endproperty
  a_disabledHiZ: assert property (p_disabledHiZ) else $error("disabled output drives");

  property p_needEnable;
    @(posedge sys_clk) disable iff (!rst_n)
      !s_q.en[0] |=> !pins[0].posOe;
  endproperty
  a_needEnable: assert property (p_needEnable) else $error("output drives without enable");

  property p_bothOn;
    @(posedge sys_clk) disable iff (!rst_n)
      s_q.en[0] && s_q.cfg[0].fmt inside {[4'h1:4'h7]} |=> pins[0].posOe;
  endproperty
  a_bothOn: assert property (p_bothOn) else $error("enabled output not driving");

  property p_fixedSwing;
    @(posedge sys_clk) disable iff (!rst_n)
      s_q.cfg[0].fmt == 4'h1 |=> drv[0].swing == `OCDF_FIXED_SWING
        && drv[0].cm == $past(s_q.cfg[0].cm);
  endproperty
  a_fixedSwing: assert property (p_fixedSwing) else $error("fixed swing not forced");

  property p_progSwing;
    @(posedge sys_clk) disable iff (!rst_n)
      s_q.cfg[0].fmt == 4'h2 |=> drv[0].swing == $past(s_q.cfg[0].swing);
  endproperty
  a_progSwing: assert property (p_progSwing) else $error("programmed swing lost");

  property p_cmosInv;
    @(posedge sys_clk) disable iff (!rst_n)
      active[0] && s_q.cfg[0].fmt == 4'h6 && !dual[0] |=> pins[0].neg != pins[0].pos;
  endproperty
  a_cmosInv: assert property (p_cmosInv) else $error("negative pin not inverted");

  property p_drive;
    @(posedge sys_clk) disable iff (!rst_n)
      1'b1 |=> drv[0].drive == $past(s_q.cfg[0].drive);
  endproperty
  a_drive: assert property (p_drive) else $error("drive strength not applied");

  property p_bypassInvert;
    @(posedge sys_clk) disable iff (!rst_n)
      active[0] && s_q.cfg[0].msd == 7'h00 && s_q.cfg[0].fmt inside {[4'h1:4'h7]}
        |=> pins[0].pos == ($past(srcLvl[0]) ^ $past(s_q.cfg[0].inv));
  endproperty
  a_bypassInvert: assert property (p_bypassInvert) else $error("bypass path wrong");

  c_diffActive: cover property (@(posedge sys_clk) disable iff (!rst_n)
    active[0] && s_q.cfg[0].fmt == 4'h2);
  c_dualMode: cover property (@(posedge sys_clk) disable iff (!rst_n)
    active[0] && dual[0] && s_q.cfg[0].fmt == 4'h5);
  c_apbWrite: cover property (@(posedge sys_clk) disable iff (!rst_n)
    psel && penable && pwrite && !pslverr);

endmodule

// File: dv/ocdf_clock_receiver.sv
// downstream clock receiver model for one output pair
`timescale 1ns/1ns
module ocdf_clock_receiver (
  input wire logic sys_clk,
  input wire ocdf_pkg::ocdf_pin_t pin,
  output int posHigh,
  output int posLow,
  output int negHalf,
  output int posEdges
);
  logic floatPat = 1'b0;
  logic posLast = 1'b0;
  logic negLast = 1'b0;
  logic posLine;
  logic negLine;
  int posCnt = 0;
  int negCnt = 0;
  // released pins show a level that changes every cycle
  assign posLine = pin.posOe ? pin.pos : floatPat;
  assign negLine = pin.negOe ? pin.neg : floatPat;
  ////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    floatPat <= ~floatPat;
    posLast <= posLine;
    negLast <= negLine;
    posCnt <= (posLine != posLast) ? 1 : posCnt + 1;
    negCnt <= (negLine != negLast) ? 1 : negCnt + 1;
    if (posLine != posLast) begin
      if (posLast) begin
        posHigh <= posCnt;
      end else begin
        posLow <= posCnt;
      end
      posEdges <= posEdges + 1;
    end
    if (negLine != negLast) begin
      negHalf <= negCnt;
    end
  end
endmodule

// File: dv/ocdf_output_ctrl_tb.sv
// self-checking bench for the output clock control block
`timescale 1ns/1ns
`include "ocdf_defs.svh"
module ocdf_output_ctrl_tb;
  typedef struct packed {logic [31:0] data; logic err;} ocdf_note_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] srcClk = 4'h0;
  ocdf_pkg::ocdf_pin_t [5:0] pins;
  ocdf_pkg::ocdf_drv_t [5:0] drv;
  ocdf_note_t notes[$];
  ocdf_note_t note;
  int mismatches = 0;
  int total_checks = 0;
  int posHigh;
  int posLow;
  int negHalf;
  int posEdges;
  integer seed = 32'h8647;
  int srcHalf[4] = '{4, 3, 5, 6};
  int srcCnt[4] = '{0, 0, 0, 0};
  int msd;
  logic [31:0] d;

  ocdf_output_ctrl #(.NumOutputs(6), .NumBanks(6)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .srcClk(srcClk), .pins(pins),
    .drv(drv));
  ocdf_clock_receiver rx (.sys_clk(sys_clk), .pin(pins[0]), .posHigh(posHigh),
    .posLow(posLow), .negHalf(negHalf), .posEdges(posEdges));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////
  // four source clocks, each slower than half the system clock
  always @(posedge sys_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (srcCnt[k] == srcHalf[k] - 1) begin
        srcCnt[k] <= 0;
        srcClk[k] <= ~srcClk[k];
      end else begin
        srcCnt[k] <= srcCnt[k] + 1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     input logic [31:0] exp, input logic err);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    notes.push_back(ocdf_note_t'{exp, err});
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic err = 1'b0);
    apb(1'b1, a, wd, 32'h0, err);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err = 1'b0);
    apb(1'b0, a, 32'h0, exp, err);
  endtask

  function automatic logic [11:0] ra(input int i, input logic [4:0] sub);
    ra = 12'(`OCDF_OUT_BASE + (i << `OCDF_OUT_SHIFT) + sub);
  endfunction

  task automatic settle(input int edges);
    int n;
    int start;
    n = 0;
    start = posEdges;
    while (posEdges - start < edges && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      end_of_test();
    end
  endtask

  // output 0: bank source, mid field, low path selects, low field
  task automatic cfg(input int k, input int m, input logic [1:0] sel, input logic [23:0] ls);
    wr(`OCDF_MUX_OFFS, 32'(k));
    wr(ra(0, `OCDF_CR1_SUB), 32'(m));
    wr(ra(0, `OCDF_CR3_SUB), {30'h0, sel});
    wr(ra(0, `OCDF_DIV_SUB), {8'h0, ls});
    settle(16);
  endtask
  ////////////////////////////////////////////////////////////////
  // bus watcher takes the oldest note at each completed transfer
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      check(32'(pslverr), 32'(note.err), "pslverr");
      if (!pwrite) begin
        check(prdata, note.data, "prdata");
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`OCDF_ENABLE_OFFS, 32'h0);
    rd(ra(0, `OCDF_CR2_SUB), 32'h60);
    rd(ra(0, `OCDF_DIFF_SUB), 32'h08);
    rd(ra(5, `OCDF_CR2_SUB), 32'h60);
    rd(ra(6, `OCDF_CR2_SUB), 32'h0, 1'b1);
    wr(`OCDF_STATUS_OFFS, 32'hFFFF, 1'b1);
    d = $random(seed);
    wr(ra(0, `OCDF_CR1_SUB), d);
    rd(ra(0, `OCDF_CR1_SUB), d & 32'h7F);
    check(32'(drv[0].lowPower), 32'h1, "low power");
    $display("test registers done");
    wr(ra(0, `OCDF_CR2_SUB), 32'h5);
    wr(`OCDF_ENABLE_OFFS, 32'h1);
    for (int k = 0; k < 4; k++) begin
      msd = 1 + ($unsigned($random(seed)) % 4);
      cfg(k, msd, 2'h0, 24'h0);
      check(posHigh, srcHalf[k] * (msd + 1), "high");
      check(posLow, srcHalf[k] * (msd + 1), "low");
    end
    cfg(0, 0, 2'h1, 24'h2);
    check(posHigh, srcHalf[0], "bypass");
    cfg(1, 2, 2'h1, 24'h2);
    check(posHigh, 27, "low high");
    check(posLow, 27, "low low");
    cfg(0, 1, 2'h2, 24'h4);
    check(posHigh, 8, "dual pos");
    check(negHalf, 40, "dual neg");
    cfg(0, 2, 2'h0, 24'h0);
    $display("test dividers done");
    wr(ra(0, `OCDF_DIFF_SUB), 32'h5B);
    for (int f = 0; f < 9; f++) begin
      wr(ra(0, `OCDF_CR2_SUB), 32'(f) | 32'(f % 4) << 5);
      repeat (2) @(posedge sys_clk);
      check(32'(pins[0].posOe), 32'(f != 0 && f < 8), "pos enable");
      check(32'(pins[0].negOe), 32'(f != 0 && f != 4 && f < 8), "neg enable");
      check(32'(drv[0].lowPower), 32'(f == 0 || f == 8), "low power");
      if (f >= 4) check(32'(drv[0].drive), 32'(f % 4), "drive");
      if (f == 1) check(32'(drv[0].swing), 32'(`OCDF_FIXED_SWING), "fixed");
      if (f == 2) check(32'(drv[0].swing), 32'hB, "swing");
      if (f == 1 || f == 2) check(32'(drv[0].cm), 32'h5, "cm");
      for (int c = 0; c < 6 && f != 0 && f != 4 && f < 8; c++) begin
        @(posedge sys_clk);
        #1;
        check(32'(pins[0].neg), 32'(f == 5 ? pins[0].pos : !pins[0].pos), "neg");
      end
    end
    $display("test formats done");
    wr(ra(0, `OCDF_CR2_SUB), 32'h5);
    wr(`OCDF_ENABLE_OFFS, 32'h0);
    repeat (2) @(posedge sys_clk);
    check(32'(pins[0].posOe | pins[0].negOe), 32'h0, "enable off");
    rd(`OCDF_STATUS_OFFS, 32'h0);
    wr(ra(1, `OCDF_CR1_SUB), 32'h2);
    wr(ra(1, `OCDF_CR2_SUB), 32'h15);
    wr(`OCDF_ENABLE_OFFS, 32'h3);
    repeat (2) @(posedge sys_clk);
    for (int c = 0; c < 24; c++) begin
      @(posedge sys_clk);
      #1;
      check(32'(pins[1].pos), 32'(!pins[0].pos), "invert");
    end
    $display("test invert done");
    end_of_test();
  end
endmodule
